/* hdl/pwd_watchdog.sv */
/*
   Process-data and host-interface watchdogs with shared tick prescaler and
   a byte-wide register port shared by network side and host side.
   Assumes all inputs are synchronous to clk, driven by logic on the same clock,
   so none passes a synchroniser; csr_rdata is valid the cycle after csr_rd.
   host_access and sync_write_trig are one-cycle activity pulses, and the
   register port never carries a read and a write in the same cycle.
   csr_from_net tells the two register masters apart; only the network side
   may change the configuration or clear the expiry counters.
*/
`timescale 1ns/1ns
`include "pwd_defs.svh"

module pwd_watchdog (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [11:0] csr_addr,
   input wire logic csr_wr,
   input wire logic csr_rd,
   input wire logic csr_from_net,
   input wire logic [7:0] csr_wdata,
   output logic [7:0] csr_rdata,
   input wire logic host_access,
   input wire logic sync_write_trig,
   output logic host_timer_state_bit,
   output logic proc_timer_state,
   output logic process_expiry_event
);

   // -----------------------------------------------------------------
   // helper functions
   // -----------------------------------------------------------------

   // one step of a supervision timer; restart beats expiry in the same cycle
   // fire is a one-cycle flag that feeds the counters and, for the process timer only, the event bit
   function automatic pwd_pkg::pwd_tmr_t tmr_step(
      input pwd_pkg::pwd_tmr_t t,
      input logic [15:0] tout,
      input logic tick,
      input logic restart
   );
      pwd_pkg::pwd_tmr_t n;
      n = t;
      n.fire = 1'b0;
      if (restart) begin
         n.rem = tout;
         n.expired = 1'b0;
      end else if (tout == `PWD_ZERO16) begin
         n.expired = 1'b0;
      end else if (tick && !t.expired) begin
         if (t.rem <= `PWD_ONE16) begin
            n.rem = `PWD_ZERO16;
            n.expired = 1'b1;
            n.fire = 1'b1;
         end else begin
            n.rem = t.rem - `PWD_ONE16;
         end
      end
      return n;
   endfunction : tmr_step

   // saturating expiry counter
   // stops at the ceiling so a long fault does not wrap to a small count
   function automatic logic [7:0] sat_inc(input logic [7:0] c, input logic hit);
      if (hit && c != `PWD_CNT_MAX) begin
         return c + `PWD_ONE8;
      end
      return c;
   endfunction : sat_inc

   // byte-lane write into a 16-bit register, low byte at the even address
   // each byte lands on its own, so a half-written word is live at once
   function automatic logic [15:0] wr_lane(
      input logic [15:0] old,
      input logic hi,
      input logic [7:0] d
   );
      if (hi) begin
         return {d, old[7:0]};
      end
      return {old[15:8], d};
   endfunction : wr_lane

   // -----------------------------------------------------------------
   // state and decode
   // -----------------------------------------------------------------
   // one packed record carries every flop of the block
   pwd_pkg::pwd_state_t r;
   pwd_pkg::pwd_state_t next_r;

   // decode helpers, combinational from the current inputs and state
   logic [11:0] word_addr;
   logic lane_hi;
   logic net_wr;
   logic tick;
   logic host_restart;
   logic cnt_clear;
   logic state_rd;

   // even byte address of the word, and which byte lane of it
   assign word_addr = {csr_addr[11:1], 1'b0};
   assign lane_hi = csr_addr[`PWD_ADDR_LSB];
   // the host side can never write the configuration
   assign net_wr = csr_wr && csr_from_net;
   // tick every presc+2 clocks; >= guards a prescaler lowered under the count
   assign tick = r.div >= ({1'b0, r.presc} + `PWD_TICK_EXTRA - 17'h00001);
   // any host-side register access counts as host activity
   assign host_restart = host_access || ((csr_wr || csr_rd) && !csr_from_net);
   // either counter byte written from the network side clears both
   assign cnt_clear = net_wr &&
      (csr_addr == `PWD_OFS_PROC_CNT || csr_addr == `PWD_OFS_HOST_CNT);
   // either status byte read clears the event
   assign state_rd = csr_rd && word_addr == `PWD_OFS_PROC_ST;

   // -----------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      next_r = r;
      // prescaler divider
      next_r.div = tick ? 17'h00000 : r.div + 17'h00001;
      // timers
      // a restart in the same cycle as a tick wins, so a busy host never trips
      next_r.host = tmr_step(r.host, r.host_to, tick, host_restart);
      next_r.proc = tmr_step(r.proc, r.proc_to, tick, sync_write_trig);
      // expiry counters; a clear and an expiry together leave one count
      if (cnt_clear) begin
         next_r.proc_cnt = next_r.proc.fire ? `PWD_ONE8 : `PWD_ZERO8;
         next_r.host_cnt = next_r.host.fire ? `PWD_ONE8 : `PWD_ZERO8;
      end else begin
         next_r.proc_cnt = sat_inc(r.proc_cnt, next_r.proc.fire);
         next_r.host_cnt = sat_inc(r.host_cnt, next_r.host.fire);
      end
      // event request bit: a new expiry wins over the read that clears it
      next_r.event_req = next_r.proc.fire || (r.event_req && !state_rd);
      // configuration writes, network side only
      // a timeout write leaves the running count alone; only a restart reloads
      if (net_wr) begin
         unique case (word_addr)
            `PWD_OFS_PRESC: next_r.presc = wr_lane(r.presc, lane_hi, csr_wdata);
            `PWD_OFS_HOST_TO: next_r.host_to = wr_lane(r.host_to, lane_hi, csr_wdata);
            `PWD_OFS_PROC_TO: next_r.proc_to = wr_lane(r.proc_to, lane_hi, csr_wdata);
            default: next_r.presc = r.presc;
         endcase
      end
      // registered read data, unmapped bytes read zero
      // csr_rdata is a flop and stands until the next read
      if (csr_rd) begin
         unique case (csr_addr)
            `PWD_OFS_PRESC: next_r.rdata = r.presc[7:0];
            `PWD_OFS_PRESC + 12'h001: next_r.rdata = r.presc[15:8];
            `PWD_OFS_HOST_TO: next_r.rdata = r.host_to[7:0];
            `PWD_OFS_HOST_TO + 12'h001: next_r.rdata = r.host_to[15:8];
            `PWD_OFS_PROC_TO: next_r.rdata = r.proc_to[7:0];
            `PWD_OFS_PROC_TO + 12'h001: next_r.rdata = r.proc_to[15:8];
            `PWD_OFS_PROC_ST: next_r.rdata = {7'h00, proc_timer_state};
            `PWD_OFS_PROC_ST + 12'h001: next_r.rdata = 8'h00;
            `PWD_OFS_PROC_CNT: next_r.rdata = r.proc_cnt;
            `PWD_OFS_HOST_CNT: next_r.rdata = r.host_cnt;
            default: next_r.rdata = 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   // timers start expired so state reads 0 until first restart or a zero timeout write
   // the divider starts from zero so the first tick is a full period
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r.div <= 17'h00000;
         r.presc <= `PWD_RST_PRESC;
         r.host_to <= `PWD_RST_TIMEOUT;
         r.proc_to <= `PWD_RST_TIMEOUT;
         r.host <= '{rem: `PWD_ZERO16, expired: 1'b1, fire: 1'b0};
         r.proc <= '{rem: `PWD_ZERO16, expired: 1'b1, fire: 1'b0};
         r.host_cnt <= `PWD_ZERO8;
         r.proc_cnt <= `PWD_ZERO8;
         r.event_req <= 1'b0;
         r.rdata <= 8'h00;
      end else begin
         r <= next_r;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // state outputs read 1 while active or disabled, 0 once expired
   assign csr_rdata = r.rdata;
   assign host_timer_state_bit = !r.host.expired;
   assign proc_timer_state = !r.proc.expired;
   assign process_expiry_event = r.event_req;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // every check except a_presc_reset, a_host_tick and a_proc_tick looks one clock after its trigger, at the flops that the
   // trigger updates; expected values come from the rules, and the
   // next-state record only qualifies antecedents
   // where an expiry and a clear meet in one cycle, the antecedent steps aside

   // divider and tick: the shortest legal period is two clocks
   a_tick_period: assert property (tick |=> !tick && r.div == 17'h00000)
      else $error("tick came sooner than prescaler plus two");
   a_div_count: assert property (!tick |=> r.div == $past(r.div) + 17'h00001)
      else $error("divider skipped a count");
   a_presc_reset: assert property ($fell(sys_rst) |-> r.presc == `PWD_RST_PRESC)
      else $error("prescaler reset value wrong");

   // host timer: counts only on ticks, restart, disable by zero
   a_host_tick: assert property ($rose(r.host.expired) && !$past(sys_rst)
      |-> $past(tick))
      else $error("host timer expired between ticks");
   a_host_hold: assert property (!tick && !host_restart |=> $stable(r.host.rem))
      else $error("host timer moved without a tick");
   a_host_disabled: assert property (r.host_to == `PWD_ZERO16 |=> host_timer_state_bit)
      else $error("disabled host timer shows expired");
   a_host_restart: assert property (host_restart |=> r.host.rem == $past(r.host_to))
      else $error("host access did not reload host timer");
   a_host_active: assert property (host_restart |=> host_timer_state_bit)
      else $error("host timer not active after host access");
   a_host_shown: assert property (next_r.host.fire |=> !host_timer_state_bit)
      else $error("host expiry not shown on state bit");

   // process timer: same scheme, restarted by enabled sync-channel writes
   a_proc_tick: assert property ($rose(r.proc.expired) && !$past(sys_rst)
      |-> $past(tick))
      else $error("process timer expired between ticks");
   a_proc_hold: assert property (!tick && !sync_write_trig |=> $stable(r.proc.rem))
      else $error("process timer moved without a tick");
   a_proc_restart: assert property (sync_write_trig |=>
      proc_timer_state && r.proc.rem == $past(r.proc_to))
      else $error("process timer not reloaded by trigger");
   a_proc_disabled: assert property (r.proc_to == `PWD_ZERO16 |=> proc_timer_state)
      else $error("disabled process timer shows expired");
   a_proc_fire: assert property (next_r.proc.fire |=> !proc_timer_state)
      else $error("process expiry not shown as state zero");

   // status register, read data and event bit
   a_state_lower: assert property (csr_rd && csr_addr == `PWD_OFS_PROC_ST |=>
      csr_rdata == {7'h00, $past(proc_timer_state)})
      else $error("status low byte does not show timer state");
   a_state_upper: assert property (csr_rd && csr_addr == `PWD_OFS_PROC_ST + 12'h001 |=>
      csr_rdata == 8'h00)
      else $error("status upper byte not zero");
   a_unmapped_rd: assert property (csr_rd && csr_addr == `PWD_OFS_HOST_CNT + 12'h001
      |=> csr_rdata == 8'h00)
      else $error("unmapped byte did not read zero");
   a_event_set: assert property (next_r.proc.fire |=> process_expiry_event)
      else $error("process expiry did not raise event");
   a_event_clear: assert property (state_rd && !next_r.proc.fire |=>
      !process_expiry_event)
      else $error("status read did not clear event");
   a_rdata_hold: assert property (!csr_rd |=> $stable(csr_rdata))
      else $error("read data changed without a read");

   // expiry counters
   a_proc_count: assert property (next_r.proc.fire && !cnt_clear
      && r.proc_cnt != `PWD_CNT_MAX |=> r.proc_cnt == $past(r.proc_cnt) + `PWD_ONE8)
      else $error("process expiry not counted");
   a_proc_sat: assert property (r.proc_cnt == `PWD_CNT_MAX && !cnt_clear
      |=> r.proc_cnt == `PWD_CNT_MAX)
      else $error("process counter left saturation");
   a_host_count: assert property (next_r.host.fire && !cnt_clear
      && r.host_cnt != `PWD_CNT_MAX |=> r.host_cnt == $past(r.host_cnt) + `PWD_ONE8)
      else $error("host expiry not counted");
   a_host_sat: assert property (r.host_cnt == `PWD_CNT_MAX && !cnt_clear
      |=> r.host_cnt == `PWD_CNT_MAX)
      else $error("host counter left saturation");
   a_cnt_clear: assert property (cnt_clear && !next_r.proc.fire && !next_r.host.fire
      |=> r.proc_cnt == `PWD_ZERO8 && r.host_cnt == `PWD_ZERO8)
      else $error("counter write did not clear both");
   a_cnt_host_ro: assert property (csr_wr && !csr_from_net && !next_r.proc.fire
      && !next_r.host.fire |=> $stable(r.proc_cnt) && $stable(r.host_cnt))
      else $error("host side write changed a counter");

   // configuration: byte lanes and network-side ownership
   a_lane_low: assert property (net_wr && csr_addr == `PWD_OFS_PRESC
      |=> r.presc == {$past(r.presc[15:8]), $past(csr_wdata)})
      else $error("low byte write hit the wrong lane");
   a_lane_high: assert property (net_wr && csr_addr == `PWD_OFS_PRESC + 12'h001
      |=> r.presc == {$past(csr_wdata), $past(r.presc[7:0])})
      else $error("high byte write hit the wrong lane");
   a_host_nowrite: assert property (csr_wr && !csr_from_net
      |=> $stable(r.presc) && $stable(r.host_to) && $stable(r.proc_to))
      else $error("host side changed configuration");
   a_cfg_hold: assert property (!net_wr |=> $stable(r.host_to) && $stable(r.proc_to))
      else $error("timeout changed without a network write");

   // main scenarios reached
   c_proc_expire: cover property (sync_write_trig ##[1:20] $fell(proc_timer_state));
   c_host_expire: cover property ($fell(host_timer_state_bit));
   c_event_read: cover property (process_expiry_event ##1 state_rd);
   c_cnt_clear: cover property (r.host_cnt != `PWD_ZERO8 ##1 cnt_clear);
   c_proc_sat: cover property (r.proc_cnt == `PWD_CNT_MAX);

endmodule : pwd_watchdog

/* hdl/pwd_defs.svh */
/*
   Constants for the process and host watchdog: byte offsets, reset values and widths.
   Assumes inclusion by the watchdog package and module only.
*/
// How it works
// - tick period is prescaler plus two clocks
// - prescaler resets to 09C2h, 100 us tick
// - host timeout 16-bit ticks, resets to 03E8h
// - host timeout of zero disables host timer
// - any host-side access restarts host timer
// - process timeout 16-bit ticks, resets to 03E8h
// - one process timer, restarted by enabled channel writes
// - process state in bit 0, upper bits zero
// - reading process state clears expiry event bit
// - process expiry counter saturates at FFh
// - host expiry counter saturates at FFh
// - network write clears both counters, host read-only
// - host state shown on link-layer status bit
// - multi-byte registers are little-endian by address
`ifndef PWD_DEFS_SVH
`define PWD_DEFS_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define PWD_ADDR_W 12
`define PWD_OFS_PRESC 12'h400
`define PWD_OFS_HOST_TO 12'h410
`define PWD_OFS_PROC_TO 12'h420
`define PWD_OFS_PROC_ST 12'h440
`define PWD_OFS_PROC_CNT 12'h442
`define PWD_OFS_HOST_CNT 12'h443

// -----------------------------------------------------------------
// reset values and field limits
// -----------------------------------------------------------------
`define PWD_RST_PRESC 16'h09C2
`define PWD_RST_TIMEOUT 16'h03E8
`define PWD_CNT_MAX 8'hFF
`define PWD_TICK_EXTRA 17'h00002
`define PWD_ZERO16 16'h0000
`define PWD_ONE16 16'h0001
`define PWD_ZERO8 8'h00
`define PWD_ONE8 8'h01
`define PWD_STATE_BIT 0
`define PWD_ADDR_LSB 0

`endif

/* hdl/pwd_pkg.sv */
/*
   Types for the process and host watchdog: timer record and whole-block state.
   Assumes pwd_defs.svh is reachable on the include path.
*/
`include "pwd_defs.svh"

package pwd_pkg;

   // one supervision timer
   typedef struct packed {
      logic [15:0] rem;
      logic expired;
      logic fire;
   } pwd_tmr_t;

   // all state of the block
   typedef struct packed {
      logic [16:0] div;
      logic [15:0] presc;
      logic [15:0] host_to;
      logic [15:0] proc_to;
      pwd_tmr_t host;
      pwd_tmr_t proc;
      logic [7:0] host_cnt;
      logic [7:0] proc_cnt;
      logic event_req;
      logic [7:0] rdata;
   } pwd_state_t;

endpackage : pwd_pkg

/* test/pwd_partner.sv */
/*
   Far-side model: host processor and sync-channel write activity.
   Assumes the bench calls its task while clk is running.
*/
`timescale 1ns/1ns
module pwd_partner (
   input wire logic clk,
   output logic host_access,
   output logic sync_write_trig
);
   // both activity lines idle until a pulse is asked for
   initial begin
      host_access = 1'b0;
      sync_write_trig = 1'b0;
   end
   // one-cycle pulse, moved on falling edges so the rising edge sees it settled
   task automatic pulse(input logic host);
      @(negedge clk);
      host_access = host;
      sync_write_trig = !host;
      @(negedge clk);
      host_access = 1'b0;
      sync_write_trig = 1'b0;
   endtask : pulse
endmodule : pwd_partner

/* test/tb_top.sv */
/*
   Self-checking bench for the process and host watchdog.
   Assumes pwd_watchdog and pwd_partner are compiled beforehand.
*/
`timescale 1ns/1ns
module tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] csr_addr = 12'h000;
   logic csr_wr = 1'b0;
   logic csr_rd = 1'b0;
   logic csr_from_net = 1'b1;
   logic [7:0] csr_wdata = 8'h00;
   logic [7:0] csr_rdata;
   logic host_access, sync_write_trig, host_bit, proc_bit, proc_evt;
   int err_count = 0;
   int total_checks = 0;

   // 10 MHz clock
   always #50 clk = ~clk;

   pwd_watchdog dut (.clk(clk), .sys_rst(sys_rst), .csr_addr(csr_addr), .csr_wr(csr_wr),
      .csr_rd(csr_rd), .csr_from_net(csr_from_net), .csr_wdata(csr_wdata),
      .csr_rdata(csr_rdata), .host_access(host_access), .sync_write_trig(sync_write_trig),
      .host_timer_state_bit(host_bit), .proc_timer_state(proc_bit),
      .process_expiry_event(proc_evt));
   pwd_partner far (.clk(clk), .host_access(host_access), .sync_write_trig(sync_write_trig));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   // one byte access; strobe lives for exactly one rising edge
   task automatic acc(input logic wr, input logic net, input logic [11:0] a,
                      input logic [7:0] d);
      @(negedge clk);
      csr_addr = a;
      csr_wdata = d;
      csr_from_net = net;
      csr_wr = wr;
      csr_rd = !wr;
      @(negedge clk);
      csr_wr = 1'b0;
      csr_rd = 1'b0;
   endtask : acc
   task automatic rd(input logic net, input logic [11:0] a, input logic [7:0] exp);
      acc(1'b0, net, a, 8'h00);
      chk(csr_rdata, exp);
   endtask : rd
   // bounded wait, since expiry time depends on tick phase
   task automatic wait_low(input logic host);
      for (int k = 0; k < 40; k++) begin
         if ((host ? host_bit : proc_bit) === 1'b0) break;
         @(negedge clk);
      end
   endtask : wait_low
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset;
      rd(1'b1, 12'h400, 8'hC2);
      rd(1'b1, 12'h401, 8'h09);
      rd(1'b0, 12'h410, 8'hE8);
      rd(1'b0, 12'h411, 8'h03);
      rd(1'b1, 12'h420, 8'hE8);
      rd(1'b1, 12'h421, 8'h03);
      rd(1'b1, 12'h441, 8'h00);
      rd(1'b1, 12'h444, 8'h00);
      acc(1'b1, 1'b0, 12'h400, 8'h55);
      rd(1'b1, 12'h400, 8'hC2);
      $display("reset test done");
   endtask : test_reset
   task automatic test_proc;
      acc(1'b1, 1'b1, 12'h400, 8'h00);
      acc(1'b1, 1'b1, 12'h401, 8'h00);
      acc(1'b1, 1'b1, 12'h420, 8'h03);
      acc(1'b1, 1'b1, 12'h421, 8'h00);
      far.pulse(1'b0);
      chk({7'h00, proc_bit}, 8'h01);
      repeat (3) @(negedge clk);
      chk({7'h00, proc_bit}, 8'h01);
      repeat (2) @(negedge clk);
      chk({7'h00, proc_bit}, 8'h00);
      chk({7'h00, proc_evt}, 8'h01);
      rd(1'b1, 12'h442, 8'h01);
      rd(1'b0, 12'h440, 8'h00);
      @(negedge clk);
      chk({7'h00, proc_evt}, 8'h00);
      acc(1'b1, 1'b1, 12'h420, 8'h00);
      repeat (20) @(negedge clk);
      rd(1'b1, 12'h440, 8'h01);
      // shortest timeout so the counter reaches its ceiling quickly
      acc(1'b1, 1'b1, 12'h420, 8'h01);
      repeat (300) begin
         far.pulse(1'b0);
         wait_low(1'b0);
      end
      rd(1'b1, 12'h442, 8'hFF);
      $display("process timer test done");
   endtask : test_proc
   task automatic test_host;
      acc(1'b1, 1'b1, 12'h410, 8'h03);
      acc(1'b1, 1'b1, 12'h411, 8'h00);
      repeat (10) begin
         far.pulse(1'b1);
         repeat (2) @(negedge clk);
      end
      chk({7'h00, host_bit}, 8'h01);
      wait_low(1'b1);
      chk({7'h00, host_bit}, 8'h00);
      rd(1'b1, 12'h443, 8'h01);
      // the ignored host write still restarts the host timer, so let it expire again
      acc(1'b1, 1'b0, 12'h443, 8'h00);
      wait_low(1'b1);
      rd(1'b1, 12'h443, 8'h02);
      acc(1'b1, 1'b1, 12'h442, 8'h00);
      rd(1'b1, 12'h443, 8'h00);
      rd(1'b1, 12'h442, 8'h00);
      acc(1'b1, 1'b1, 12'h410, 8'h00);
      repeat (20) @(negedge clk);
      chk({7'h00, host_bit}, 8'h01);
      rd(1'b1, 12'h440, 8'h00);
      $display("host timer test done");
   endtask : test_host

   // main sequence: reset for four cycles, then the scenarios
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      test_reset();
      test_proc();
      test_host();
      end_of_test();
   end
   // hang guard, well beyond the roughly 1400 cycles the scenarios need
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test();
   end
endmodule : tb_top
